// ==== design/pdld_core.sv ====
// Notes on behaviour
// R1: settled output pin is low while locked, high otherwise.
// R2: lock detector selectable between phase-match and frequency-match modes.
// R3: phase-match mode reports lock as soon as lock is seen.
// R4: frequency-match mode waits a programmed 16..256 detector cycles of held lock.
// R5: settled indication drops at once when lock is lost, either mode.
// R6: frequency-match mode may keep lock asserted when the reference stops; here a second feedback pulse with no reference pulse drops it.
// R7: phase-match mode always drops lock when the reference is lost.
// R8: input prescaler divides the reference by an integer 1..32.
// R9: feedback prescaler divides the feedback by an integer 1..32.
// R10: five output dividers each take an even ratio 2..64.
// R11: feedback taken from any one output divider, which still drives its output.
// R12: locked, bypass low: outputs run at fref*N*Vfbk/(M*Vk).
// R13: ratio 2 or multiple of 4 gives 50% duty, others do not.
// R14: inverted output has the complement duty cycle.
// R15: charge-pump field has 14 values, resistor field six, any combination.
// R16: configurer keeps feedback prescaler times feedback divider at most 64.
// R17: configurer keeps prescaler outputs at or above 10 MHz, smallest input ratio.
// R18: configurer doubles the feedback product for filter choice in coarse skew.
// R19: bypass routes input prescaler to dividers, halved ratios, 1..32.
// R20: bypass provides no lock detection and no skew.
// R21: qualification counter restarts from zero whenever lock drops early.
`timescale 1ns/10ps
`default_nettype none

module pdld_core
   import pdld_pkg::*;
#(
   parameter int REF_LOSS = REF_LOSS_CYCLES
)
(
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   sys_rst,
   // reference clock, sampled level
   input  wire logic                   refClk,
   // divider configuration
   input  wire logic [5:0]             refDivRatio,
   input  wire logic [5:0]             fbkDivRatio,
   input  wire logic [4:0][6:0]        outDivRatio,
   input  wire logic [4:0]             outInvert,
   input  wire logic [2:0]             fbkSelect,
   input  wire logic                   pllBypass,
   // lock detector configuration
   input  wire logic                   freqLockMode,
   input  wire logic [8:0]             lockQualCount,
   // loop filter configuration
   input  wire logic [3:0]             cpCurrentSel,
   input  wire logic [2:0]             filterResSel,
   // outputs
   output logic [4:0]                  clkOut,
   output logic                        loopSettled_n,
   output logic [3:0]                  cpCurrent,
   output logic [2:0]                  filterRes
);

   function automatic logic [6:0] clampPre(input logic [5:0] r);
      logic [6:0] w;
      w = {1'b0, r};
      if (w < PDLD_PRE_MIN)
         return PDLD_PRE_MIN;
      else if (w > PDLD_PRE_MAX)
         return PDLD_PRE_MAX;
      return w;
   endfunction

   function automatic logic [6:0] clampOut(input logic [6:0] r);
      logic [6:0] w;
      w = {r[6:1], 1'b0};
      if (w < PDLD_OUT_MIN)
         return PDLD_OUT_MIN;
      else if (w > PDLD_OUT_MAX)
         return PDLD_OUT_MAX;
      return w;
   endfunction

   // high time in ticks; only 2 and multiples of 4 come out at one half
   function automatic logic [6:0] highTimeOf(input logic [6:0] r);
      if (r == PDLD_OUT_MIN)
         return 7'h01;
      return {1'b0, r[6:2], 1'b0};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // dividers: 0..4 outputs, then input and feedback prescalers

   pdld_div_if divIf [PDLD_NUM_DIV] ();

   logic [6:0]             refRatio;
   logic [6:0]             fbkRatio;
   logic                   refPrev_q;
   logic                   refEdge;
   logic                   mPrev_q;
   logic                   bypassTick;
   logic [4:0]             outLevel;
   logic [2:0]             fbkSel;
   logic                   fbkLevel;
   logic                   fbkPrev_q;
   logic                   refPulse;
   logic                   fbkPulse;

   assign refRatio = clampPre(refDivRatio);
   assign fbkRatio = clampPre(fbkDivRatio);
   assign refEdge  = refClk ^ refPrev_q;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         refPrev_q <= 1'b0;
         mPrev_q   <= 1'b0;
         fbkPrev_q <= 1'b0;
      end
      else
      begin
         refPrev_q <= refClk;
         mPrev_q   <= divIf[PDLD_IDX_REF].level;
         fbkPrev_q <= fbkLevel;
      end
   end

   // R8 input prescaler
   // both reference edges feed a 2M counter, so its level is a square wave at fref/M
   assign divIf[PDLD_IDX_REF].tick    = refEdge;
   assign divIf[PDLD_IDX_REF].ratio   = {refRatio[5:0], 1'b0};
   assign divIf[PDLD_IDX_REF].highLen = refRatio;
   assign refPulse                    = divIf[PDLD_IDX_REF].wrap;

   // R19 bypass clocking
   // every edge of the prescaled clock is a tick: Vk ticks make Vk/2 periods
   assign bypassTick = divIf[PDLD_IDX_REF].level ^ mPrev_q;

   // R11 feedback select
   assign fbkSel   = (fbkSelect > PDLD_FBK_SEL_MAX) ? PDLD_FBK_SEL_MAX : fbkSelect;
   assign fbkLevel = outLevel[fbkSel];

   // R9 feedback prescaler
   assign divIf[PDLD_IDX_FBK].tick    = fbkLevel & ~fbkPrev_q;
   assign divIf[PDLD_IDX_FBK].ratio   = fbkRatio;
   assign divIf[PDLD_IDX_FBK].highLen = {1'b0, fbkRatio[6:1]};
   assign fbkPulse                    = divIf[PDLD_IDX_FBK].wrap;

   for (genvar g = 0; g < PDLD_NUM_OUT; g++)
   begin : gOut
      logic [6:0] vRatio;
      assign vRatio = clampOut(outDivRatio[g]);
      // R10 even ratio
      // R12 mclk stands in for the vco, so locked outputs follow the formula
      assign divIf[g].tick    = pllBypass ? bypassTick : 1'b1;
      assign divIf[g].ratio   = vRatio;
      // R13 duty by ratio
      assign divIf[g].highLen = highTimeOf(vRatio);
      assign outLevel[g]      = divIf[g].level;
   end

   for (genvar g = 0; g < PDLD_NUM_DIV; g++)
   begin : gDiv
      pdld_divider uDiv
      (
         .mclk    (mclk),
         .sys_rst (sys_rst),
         .d       (divIf[g])
      );
   end

   // R14 inverted outputs
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         clkOut <= 5'h00;
      else
         clkOut <= outLevel ^ outInvert;
   end

   ////////////////////////////////////////////////////////////////////////////
   // lock detector

   pdld_mode_t mode;
   logic       refPend_q;
   logic       fbkPend_q;
   logic       match;
   logic       missed;
   logic       phaseOk_q;
   logic [8:0] refAge_q;
   logic       refLost;
   logic [1:0] fbkSeen_q;
   logic [1:0] seenSum;
   logic       freqOk_q;
   logic       lockCond;
   logic [8:0] qualTarget;
   logic [8:0] qualCnt_q;
   logic       settled;

   // R2 mode select
   assign mode = freqLockMode ? PDLD_MODE_FREQ : PDLD_MODE_PHASE;

   // one cycle of slack either way between the two prescaler pulses
   assign match  = (refPulse && fbkPulse) || (refPend_q && fbkPulse) || (fbkPend_q && refPulse);
   assign missed = (refPend_q && !fbkPulse) || (fbkPend_q && !refPulse);

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         refPend_q <= 1'b0;
         fbkPend_q <= 1'b0;
      end
      else
      begin
         refPend_q <= refPulse && !fbkPulse && !fbkPend_q;
         fbkPend_q <= fbkPulse && !refPulse && !refPend_q;
      end
   end

   assign refLost = (refAge_q >= 9'(REF_LOSS));

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         refAge_q <= PDLD_QUAL_RST;
      else if (refPulse)
         refAge_q <= PDLD_QUAL_RST;
      else if (!refLost)
         refAge_q <= refAge_q + 9'h001;
   end

   // R7 reference loss
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         phaseOk_q <= 1'b0;
      else if (refLost || missed)
         phaseOk_q <= 1'b0;
      else if (match)
         phaseOk_q <= 1'b1;
   end

   // R6 frequency compare
   // judged at reference pulses; a second feedback pulse before the next one clears it, so a stopped reference drops the verdict
   assign seenSum = fbkSeen_q + {1'b0, fbkPulse};

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         fbkSeen_q <= PDLD_SEEN_RST;
         freqOk_q  <= 1'b0;
      end
      else if (refPulse)
      begin
         fbkSeen_q <= PDLD_SEEN_RST;
         freqOk_q  <= (seenSum == 2'h1);
      end
      else if (fbkPulse)
      begin
         fbkSeen_q <= (fbkSeen_q == 2'h2) ? fbkSeen_q : seenSum;
         if (fbkSeen_q != PDLD_SEEN_RST)
            freqOk_q <= 1'b0;
      end
   end

   // R20 no lock in bypass
   assign lockCond = !pllBypass && ((mode == PDLD_MODE_FREQ) ? freqOk_q : phaseOk_q);

   assign qualTarget = (lockQualCount < PDLD_QUAL_MIN) ? PDLD_QUAL_MIN :
                       (lockQualCount > PDLD_QUAL_MAX) ? PDLD_QUAL_MAX : lockQualCount;

   // R21 qualification restart
   always_ff @(posedge mclk)
   begin
      if (sys_rst || !lockCond)
         qualCnt_q <= PDLD_QUAL_RST;
      else if (refPulse && qualCnt_q < qualTarget)
         qualCnt_q <= qualCnt_q + 9'h001;
   end

   always_comb
   begin
      case (mode)
         // R3 immediate lock
         PDLD_MODE_PHASE: settled = lockCond;
         // R4 qualified lock
         PDLD_MODE_FREQ:  settled = lockCond && (qualCnt_q >= qualTarget);
         default:         settled = 1'b0;
      endcase
   end

   // R1 active low pin
   // R5 immediate drop
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         loopSettled_n <= 1'b1;
      else
         loopSettled_n <= !settled;
   end

   ////////////////////////////////////////////////////////////////////////////
   // loop filter fields

   // R15 filter fields
   // out-of-range codes saturate so the analog side never sees an undefined step
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         cpCurrent <= 4'h0;
         filterRes <= 3'h0;
      end
      else
      begin
         cpCurrent <= (cpCurrentSel > PDLD_CP_MAX) ? PDLD_CP_MAX : cpCurrentSel;
         filterRes <= (filterResSel > PDLD_RES_MAX) ? PDLD_RES_MAX : filterResSel;
      end
   end

endmodule

`default_nettype wire

// ==== design/pdld_pkg.sv ====
package pdld_pkg;

   localparam int PDLD_NUM_OUT = 5;
   localparam int PDLD_NUM_DIV = 7;
   localparam int PDLD_IDX_REF = 5;
   localparam int PDLD_IDX_FBK = 6;

   localparam logic [6:0] PDLD_PRE_MIN = 7'h01;
   localparam logic [6:0] PDLD_PRE_MAX = 7'h20;
   localparam logic [6:0] PDLD_OUT_MIN = 7'h02;
   localparam logic [6:0] PDLD_OUT_MAX = 7'h40;

   localparam logic [8:0] PDLD_QUAL_MIN = 9'h010;
   localparam logic [8:0] PDLD_QUAL_MAX = 9'h100;

   localparam logic [3:0] PDLD_CP_MAX  = 4'hd;
   localparam logic [2:0] PDLD_RES_MAX = 3'h5;

   localparam logic [2:0] PDLD_FBK_SEL_MAX = 3'h4;

   localparam int REF_LOSS_CYCLES = 256;

   localparam logic [6:0] PDLD_CNT_RST  = 7'h00;
   localparam logic [8:0] PDLD_QUAL_RST = 9'h000;
   localparam logic [1:0] PDLD_SEEN_RST = 2'h0;

   typedef enum logic [1:0]
   {
      PDLD_MODE_PHASE = 2'b01,
      PDLD_MODE_FREQ  = 2'b10
   } pdld_mode_t;

endpackage

// ==== design/pdld_div_if.sv ====
`timescale 1ns/10ps
`default_nettype none

interface pdld_div_if;
   logic       tick;
   logic [6:0] ratio;
   logic [6:0] highLen;
   logic       level;
   logic       wrap;

   modport ctrl
   (
      output tick,
      output ratio,
      output highLen,
      input  level,
      input  wrap
   );

   modport div
   (
      input  tick,
      input  ratio,
      input  highLen,
      output level,
      output wrap
   );
endinterface

`default_nettype wire

// ==== design/pdld_divider.sv ====
`timescale 1ns/10ps
`default_nettype none

module pdld_divider
   import pdld_pkg::*;
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic sys_rst,
   // divider port
   pdld_div_if.div   d
);

   logic [6:0] count_q;
   logic [6:0] count_d;
   logic       last;
   logic       level_q;
   logic       wrap_q;

   // ratio shrinking below count wraps at once instead of running to 127
   assign last    = (count_q >= (d.ratio - 7'h01));
   assign count_d = last ? PDLD_CNT_RST : (count_q + 7'h01);

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         count_q <= PDLD_CNT_RST;
      else if (d.tick)
         count_q <= count_d;
   end

   // level high for the first highLen ticks of each period
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         level_q <= 1'b0;
      else if (d.tick)
         level_q <= (count_d < d.highLen);
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         wrap_q <= 1'b0;
      else
         wrap_q <= d.tick && last;
   end

   assign d.level = level_q;
   assign d.wrap  = wrap_q;

endmodule

`default_nettype wire

// ==== verification/pdld_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none

module pdld_monitor
   import pdld_pkg::*;
#(
   parameter int REF_LOSS = REF_LOSS_CYCLES
)
(
   // clock and reset
   input wire logic            mclk,
   input wire logic            sys_rst,
   // stimulus
   input wire logic            refClk,
   input wire logic [4:0][6:0] outDivRatio,
   input wire logic [4:0]      outInvert,
   input wire logic            pllBypass,
   input wire logic            freqLockMode,
   input wire logic [3:0]      cpCurrentSel,
   input wire logic [2:0]      filterResSel,
   // responses
   input wire logic [4:0]      clkOut,
   input wire logic            loopSettled_n,
   input wire logic [3:0]      cpCurrent,
   input wire logic [2:0]      filterRes
);
   // cycles since the reference last moved, saturating
   logic [9:0] stillCnt_q;
   logic       refPrev_q;

   always_ff @(posedge mclk)
   begin
      refPrev_q <= refClk;
      if (sys_rst || refClk != refPrev_q)
         stillCnt_q <= 10'h000;
      else if (stillCnt_q != 10'h3ff)
         stillCnt_q <= stillCnt_q + 10'h001;
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   property p_reset_values;
      $past(sys_rst) |-> clkOut == 5'h00 && loopSettled_n && cpCurrent == 4'h0 && filterRes == 3'h0;
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("outputs not at reset values");

   property p_cp_clamp;
      !$past(sys_rst) |-> cpCurrent == (($past(cpCurrentSel) > PDLD_CP_MAX) ? PDLD_CP_MAX : $past(cpCurrentSel));
   endproperty
   a_cp_clamp: assert property (p_cp_clamp)
      else $error("charge pump code wrong");

   property p_res_clamp;
      !$past(sys_rst) |-> filterRes == (($past(filterResSel) > PDLD_RES_MAX) ? PDLD_RES_MAX : $past(filterResSel));
   endproperty
   a_res_clamp: assert property (p_res_clamp)
      else $error("resistor code wrong");

   property p_bypass_unlocked;
      $past(pllBypass) |-> loopSettled_n;
   endproperty
   a_bypass_unlocked: assert property (p_bypass_unlocked)
      else $error("settled low in bypass");

   // stopped reference must clear phase lock once the loss window runs out
   property p_ref_loss;
      !freqLockMode && stillCnt_q > REF_LOSS + 4 |-> loopSettled_n;
   endproperty
   a_ref_loss: assert property (p_ref_loss)
      else $error("settled kept after reference loss");

   property p_freq_qual;
      $fell(loopSettled_n) && freqLockMode |-> $past(loopSettled_n, 16);
   endproperty
   a_freq_qual: assert property (p_freq_qual)
      else $error("settled before qualification");

   property p_div2_toggle;
      (!pllBypass && outDivRatio[0] == 7'h02)[*4] |=> clkOut[0] != $past(clkOut[0]);
   endproperty
   a_div2_toggle: assert property (p_div2_toggle)
      else $error("ratio two output not toggling");

   // bypass ticks come only from reference edges
   property p_bypass_still;
      pllBypass && $past(pllBypass, 4) && stillCnt_q > 10'h008 && $stable(outInvert) |-> $stable(clkOut);
   endproperty
   a_bypass_still: assert property (p_bypass_still)
      else $error("bypass output moved without reference");
endmodule

bind pdld_core pdld_monitor #(.REF_LOSS(REF_LOSS)) monitor (.mclk, .sys_rst, .refClk, .outDivRatio, .outInvert,
   .pllBypass, .freqLockMode, .cpCurrentSel, .filterResSel, .clkOut, .loopSettled_n, .cpCurrent, .filterRes);

`default_nettype wire

// ==== verification/pdld_ref_source.sv ====
`timescale 1ns/10ps
`default_nettype none

module pdld_ref_source
#(
   // eight cycles a half keeps the reference above 10 MHz
   parameter int HALF = 8
)
(
   // clock
   input  wire logic mclk,
   // bench control
   input  wire logic run,
   // reference
   output var logic  refClk
);
   int cnt = 0;

   initial refClk = 1'b0;

   // a stopped source parks low with no edges
   always @(negedge mclk)
   begin
      if (!run)
      begin
         cnt <= 0;
         refClk <= 1'b0;
      end
      else if (cnt == HALF - 1)
      begin
         cnt <= 0;
         refClk <= ~refClk;
      end
      else
         cnt <= cnt + 1;
   end
endmodule

`default_nettype wire

// ==== verification/test_pll_divider_lock_detect.sv ====
`timescale 1ns/10ps
`default_nettype none

module test_pll_divider_lock_detect;
   logic            mclk = 1'b0;
   logic            sysRst = 1'b1;
   logic            refRun = 1'b0;
   logic            refClk;
   logic [5:0]      refDivRatio = 6'h01;
   logic [5:0]      fbkDivRatio = 6'h01;
   logic [4:0][6:0] outDivRatio = '0;
   logic [4:0]      outInvert = 5'h00;
   logic [2:0]      fbkSelect = 3'h0;
   logic            pllBypass = 1'b0;
   logic            freqLockMode = 1'b0;
   logic [8:0]      lockQualCount = 9'h010;
   logic [3:0]      cpCurrentSel = 4'h0;
   logic [2:0]      filterResSel = 3'h0;
   logic [4:0]      clkOut;
   logic            loopSettled_n;
   logic [3:0]      cpCurrent;
   logic [2:0]      filterRes;
   int              errors = 0;
   int              comparisons = 0;
   int              cycles = 0;
   int              hi, per, n, locks;
   int              vk [5] = '{2, 6, 14, 64, 12};

   pdld_ref_source #(.HALF(8)) refSrc (.mclk(mclk), .run(refRun), .refClk(refClk));

   // short loss window keeps the phase scan quick; still above the 16 cycle ref period
   pdld_core #(.REF_LOSS(32)) DUT (.mclk, .sys_rst(sysRst), .refClk, .refDivRatio, .fbkDivRatio, .outDivRatio,
      .outInvert, .fbkSelect, .pllBypass, .freqLockMode, .lockQualCount, .cpCurrentSel, .filterResSel, .clkOut,
      .loopSettled_n, .cpCurrent, .filterRes);

   always #2 mclk = ~mclk;

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         errors++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask

   task automatic restart();
      refRun <= 1'b0;
      sysRst = 1'b1;
      cyc(4);
      sysRst = 1'b0;
      cyc(2);
   endtask

   // first pass finds a rise, second counts one full period
   task automatic measure(input int g);
      logic p;
      p = 1'b1;
      repeat (2)
      begin
         per = 0;
         hi = 0;
         do
         begin
            per++;
            hi += int'(clkOut[g]);
            p = clkOut[g];
            cyc(1);
         end
         while (!(clkOut[g] && !p));
      end
   endtask

   task automatic settle(input logic lvl, input int lim);
      n = 0;
      while (loopSettled_n !== lvl && n < lim)
      begin
         cyc(1);
         n++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      restart();
      outInvert = 5'b00100;
      for (int g = 0; g < 5; g++)
         outDivRatio[g] = vk[g][6:0];
      cyc(4);
      for (int g = 0; g < 5; g++)
      begin
         measure(g);
         check(per, vk[g]);
         n = (vk[g] == 2) ? 1 : 2 * (vk[g] / 4);
         check(hi, outInvert[g] ? vk[g] - n : n);
      end
      // no coarse skew
      // skew is not modelled, so filter codes are picked from the plain product
      for (int i = 0; i < 16; i++)
      begin
         cpCurrentSel = 4'(i);
         filterResSel = 3'(i);
         cyc(2);
         check(cpCurrent, (i > 13) ? 13 : i);
         check(filterRes, (i % 8 > 5) ? 5 : i % 8);
      end
      pllBypass = 1'b1;
      refDivRatio = 6'h03;
      outDivRatio[0] = 7'h02;
      refRun <= 1'b1;
      cyc(120);
      measure(0);
      check(per, 48);
      check(loopSettled_n, 1'b1);
      refRun <= 1'b0;
      cyc(20);
      pllBypass = 1'b0;
      refDivRatio = 6'h01;
      // N times Vfbk stays 16, matching the ref period
      for (int r = 0; r < 2; r++)
      begin
         restart();
         freqLockMode = 1'b1;
         fbkSelect = 3'(r);
         fbkDivRatio = 6'(r + 1);
         lockQualCount = r ? 9'h100 : 9'h010;
         outDivRatio[0] = 7'h10;
         outDivRatio[1] = 7'h08;
         refRun <= 1'b1;
         settle(1'b0, 6000);
         check(n >= lockQualCount * 16 && n <= lockQualCount * 16 + 80, 1);
         outDivRatio[r] = r ? 7'h04 : 7'h08;
         settle(1'b1, 100);
         check(n <= 24, 1);
         outDivRatio[r] = r ? 7'h08 : 7'h10;
         settle(1'b0, 6000);
         check(n >= lockQualCount * 16, 1);
      end
      restart();
      freqLockMode = 1'b0;
      fbkSelect = 3'h0;
      fbkDivRatio = 6'h01;
      locks = 0;
      // only starts within one cycle of the feedback edge may lock
      for (int off = 0; off < 16; off++)
      begin
         refRun <= 1'b0;
         cyc(60);
         check(loopSettled_n, 1'b1);
         while (clkOut[0] !== 1'b0)
            cyc(1);
         while (clkOut[0] !== 1'b1)
            cyc(1);
         cyc(off);
         refRun <= 1'b1;
         cyc(96);
         locks += int'(!loopSettled_n);
      end
      check(locks, 3);
      complete_run();
   end
endmodule

`default_nettype wire
